// ===== inc/dmacc_defines.svh
// offsets, field codes, reset values and limits of the dma channel control block
// assumes it is included by bare name from the package and the design files
`ifndef DMACC_DEFINES_SVH
`define DMACC_DEFINES_SVH

// apb address width and register offsets (byte addresses)
`define DMACC_ADDR_W 12
`define DMACC_CTRL_BASE 12'h000
`define DMACC_LEN_BASE 12'h020
`define DMACC_STATUS_OFF 12'h040
`define DMACC_MASK_OFF 12'h044
`define DMACC_BANK_MASK 12'hfe0
`define DMACC_IDX_MSB 4
`define DMACC_IDX_LSB 2

// control register width and reset value
`define DMACC_CTRL_W 24
`define DMACC_CTRL_RST 24'h000000

// transfer mode codes
`define DMACC_MODE_REQ_BLOCK 3'h0
`define DMACC_MODE_REQ_WORD 3'h1
`define DMACC_MODE_REQ_LINE 3'h2
`define DMACC_MODE_EN_BLOCK 3'h3
`define DMACC_MODE_REQ_BLOCK_KEEP 3'h4
`define DMACC_MODE_REQ_WORD_KEEP 3'h5

// status layout and limits
`define DMACC_ACTIVE_LSB 8
`define DMACC_MAX_CH 8
`define DMACC_MAX_CNT_W 24

`endif

// ===== inc/dmacc_pkg.sv
// types shared by the dma channel control block
// assumes dmacc_defines.svh is on the include path
`include "dmacc_defines.svh"

package dmacc_pkg;

    // one channel control word, bit 23 at the top
    typedef struct packed {
        logic channel_enable;            // bit 23
        logic channel_irq_enable;        // bit 22
        logic [2:0] transfer_mode_sel;   // bits 21..19
        logic channel_priority_hi;       // bit 18
        logic channel_priority_lo;       // bit 17
        logic continuous_mode;           // bit 16
        logic [4:0] request_source_sel;  // bits 15..11
        logic [10:0] low_bits;           // bits 10..0, stored only
    } dmacc_ctrl_t;

    // transfer modes
    typedef enum logic [2:0] {
        DMACC_REQ_BLOCK = `DMACC_MODE_REQ_BLOCK,
        DMACC_REQ_WORD = `DMACC_MODE_REQ_WORD,
        DMACC_REQ_LINE = `DMACC_MODE_REQ_LINE,
        DMACC_EN_BLOCK = `DMACC_MODE_EN_BLOCK,
        DMACC_REQ_BLOCK_KEEP = `DMACC_MODE_REQ_BLOCK_KEEP,
        DMACC_REQ_WORD_KEEP = `DMACC_MODE_REQ_WORD_KEEP
    } dmacc_mode_t;

    // channel states, gray along idle-armed-run-done
    typedef enum logic [1:0] {
        DMACC_ST_IDLE = 2'h0,
        DMACC_ST_ARMED = 2'h1,
        DMACC_ST_RUN = 2'h3,
        DMACC_ST_DONE = 2'h2
    } dmacc_state_t;

    // register decode result
    typedef enum logic [2:0] {
        DMACC_K_NONE = 3'h0,
        DMACC_K_CTRL = 3'h1,
        DMACC_K_LEN = 3'h2,
        DMACC_K_STATUS = 3'h3,
        DMACC_K_MASK = 3'h4
    } dmacc_kind_t;

    typedef struct packed {
        dmacc_kind_t kind;
        logic [2:0] idx;
    } dmacc_dec_t;

endpackage

// ===== rtl/dmacc_sync.sv
// three-flop synchroniser with agreement filter for asynchronous request pins
// assumes pins may change at any time relative to pclk
module dmacc_sync #(
    parameter int W = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [W-1:0] pin,
    output logic [W-1:0] level
);

    // at least one request pin
    if (W < 1) begin : g_bad_w
        $error("dmacc_sync: W must be at least one");
    end

    logic [W-1:0] ff1;      // first stage, read by ff2 only
    logic [W-1:0] ff2;      // second stage
    logic [W-1:0] ff3;      // third stage
    logic [W-1:0] next_level;

    // level follows only where second and third stages agree
    always_comb begin
        next_level = (ff2 & ff3) | (level & (ff2 | ff3));
    end

    // register stages
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            ff1 <= '0;
            ff2 <= '0;
            ff3 <= '0;
            level <= '0;
        end else begin
            ff1 <= pin;
            ff2 <= ff1;
            ff3 <= ff2;
            level <= next_level;
        end
    end

endmodule // dmacc_sync

// ===== rtl/dmacc_channel.sv
// transfer sequencer for one dma channel
// assumes ctrl and len come from registers on pclk and word_done is a pclk pulse
`include "dmacc_defines.svh"

module dmacc_channel #(
    parameter int CNT_W = 24,
    parameter int LINE_WORDS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire dmacc_pkg::dmacc_ctrl_t ctrl,
    input wire logic [CNT_W-1:0] len,
    input wire logic req,
    input wire logic word_done,
    output logic word_req,
    output logic req_ack,
    output logic hw_en_clr,
    output logic block_evt,
    output logic abort_evt,
    output logic active
);

    // a counter and a line need at least one bit and one word
    if (CNT_W < 1 || LINE_WORDS < 1) begin : g_bad_param
        $error("dmacc_channel: CNT_W and LINE_WORDS must be at least one");
    end

    localparam int LW_W = $clog2(LINE_WORDS + 1);
    localparam logic [CNT_W-1:0] CNT_ONE = CNT_W'(1);
    localparam logic [LW_W-1:0] LINE_ONE = LW_W'(1);
    localparam logic [LW_W-1:0] LINE_LOAD = LW_W'(LINE_WORDS);

    dmacc_pkg::dmacc_state_t state, next_state;   // sequencer state
    dmacc_pkg::dmacc_mode_t mode_q, next_mode;    // mode latched at arm
    logic [CNT_W-1:0] cnt, next_cnt;              // words left in block
    logic [LW_W-1:0] line_cnt, next_line_cnt;     // words left in line
    logic last_word;                              // block ends with this word

    // next state and events
    always_comb begin
        next_state = state;
        next_mode = mode_q;
        next_cnt = cnt;
        next_line_cnt = line_cnt;
        req_ack = 1'b0;
        hw_en_clr = 1'b0;
        block_evt = 1'b0;
        abort_evt = 1'b0;
        last_word = (cnt <= CNT_ONE);
        case (state)
            dmacc_pkg::DMACC_ST_IDLE: begin
                // enable bit arms or starts the channel
                if (ctrl.channel_enable) begin
                    next_mode = dmacc_pkg::dmacc_mode_t'(ctrl.transfer_mode_sel);
                    next_cnt = len;
                    next_line_cnt = LINE_LOAD;
                    case (ctrl.transfer_mode_sel)
                        `DMACC_MODE_EN_BLOCK: next_state = dmacc_pkg::DMACC_ST_RUN;
                        `DMACC_MODE_REQ_BLOCK, `DMACC_MODE_REQ_WORD, `DMACC_MODE_REQ_LINE,
                        `DMACC_MODE_REQ_BLOCK_KEEP, `DMACC_MODE_REQ_WORD_KEEP:
                            next_state = dmacc_pkg::DMACC_ST_ARMED;
                        default: next_state = dmacc_pkg::DMACC_ST_IDLE; // reserved codes do nothing
                    endcase
                end
            end
            dmacc_pkg::DMACC_ST_ARMED: begin
                // wait for a peripheral request
                if (!ctrl.channel_enable) begin
                    next_state = dmacc_pkg::DMACC_ST_IDLE;
                end else if (req) begin
                    req_ack = 1'b1;
                    next_line_cnt = LINE_LOAD;
                    next_state = dmacc_pkg::DMACC_ST_RUN;
                end
            end
            dmacc_pkg::DMACC_ST_RUN: begin
                // one word in flight until the datapath reports it stored
                if (word_done) begin
                    next_cnt = last_word ? len : cnt - CNT_ONE; // reload at zero
                    next_line_cnt = line_cnt - LINE_ONE;
                    if (last_word && (mode_q != dmacc_pkg::DMACC_REQ_BLOCK_KEEP)
                            && (mode_q != dmacc_pkg::DMACC_REQ_WORD_KEEP)) begin
                        block_evt = 1'b1;
                    end
                    if (!ctrl.channel_enable) begin
                        // software stop: word stored, now halt
                        abort_evt = 1'b1;
                        next_state = dmacc_pkg::DMACC_ST_IDLE;
                    end else if (last_word) begin
                        case (mode_q)
                            dmacc_pkg::DMACC_REQ_BLOCK_KEEP,
                            dmacc_pkg::DMACC_REQ_WORD_KEEP: next_state = dmacc_pkg::DMACC_ST_ARMED;
                            default: begin
                                hw_en_clr = 1'b1;
                                next_state = dmacc_pkg::DMACC_ST_DONE;
                            end
                        endcase
                    end else begin
                        case (mode_q)
                            dmacc_pkg::DMACC_REQ_WORD,
                            dmacc_pkg::DMACC_REQ_WORD_KEEP: next_state = dmacc_pkg::DMACC_ST_ARMED;
                            dmacc_pkg::DMACC_REQ_LINE: begin
                                if (line_cnt <= LINE_ONE) begin
                                    next_state = dmacc_pkg::DMACC_ST_ARMED;
                                end
                            end
                            default: next_state = dmacc_pkg::DMACC_ST_RUN; // whole block
                        endcase
                    end
                end
            end
            dmacc_pkg::DMACC_ST_DONE: begin
                // enable is cleared now; requests ignored until rewritten
                next_state = dmacc_pkg::DMACC_ST_IDLE;
            end
            default: next_state = dmacc_pkg::DMACC_ST_IDLE;
        endcase
        word_req = (state == dmacc_pkg::DMACC_ST_RUN);
        active = (state == dmacc_pkg::DMACC_ST_RUN);
    end

    // register sequencer state
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            state <= dmacc_pkg::DMACC_ST_IDLE;
            mode_q <= dmacc_pkg::DMACC_REQ_BLOCK;
            cnt <= '0;
            line_cnt <= '0;
        end else begin
            state <= next_state;
            mode_q <= next_mode;
            cnt <= next_cnt;
            line_cnt <= next_line_cnt;
        end
    end

endmodule // dmacc_channel

// ===== rtl/dmacc_top.sv
// dma channel control: apb register file, request synchronisers, channel sequencers, interrupt
// assumes an apb master on pclk and a datapath that moves one word per word_req/word_done
//
// Implementation choices: the APB slave port and the placing of the registers.
`include "dmacc_defines.svh"

module dmacc_top #(
    parameter int NUM_CH = 6,
    parameter int CNT_W = 24,
    parameter int LINE_WORDS = 4
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [`DMACC_ADDR_W-1:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] pwdata,
    output logic [31:0] prdata,
    output logic pready,
    output logic pslverr,
    input wire logic [NUM_CH-1:0] periph_req,
    output logic [NUM_CH-1:0] req_ack,
    output logic [NUM_CH-1:0] word_req,
    input wire logic [NUM_CH-1:0] word_done,
    output logic irq
);


    ////////////////////////////////////////////////////////////////////////////
    // elaboration checks
    ////////////////////////////////////////////////////////////////////////////

    // channel index field and status layout limit the channel count
    if (NUM_CH < 1 || NUM_CH > `DMACC_MAX_CH) begin : g_bad_ch
        $error("dmacc_top: NUM_CH out of range");
    end
    // length register must fit the data bus below the reserved top
    if (CNT_W < 1 || CNT_W > `DMACC_MAX_CNT_W) begin : g_bad_cnt
        $error("dmacc_top: CNT_W out of range");
    end
    // a line holds at least one word
    if (LINE_WORDS < 1) begin : g_bad_line
        $error("dmacc_top: LINE_WORDS must be at least one");
    end

    ////////////////////////////////////////////////////////////////////////////
    // declarations
    ////////////////////////////////////////////////////////////////////////////

    dmacc_pkg::dmacc_ctrl_t ctrl [NUM_CH];       // channel control registers
    dmacc_pkg::dmacc_ctrl_t next_ctrl [NUM_CH];
    logic [CNT_W-1:0] len [NUM_CH];              // block length per channel
    logic [CNT_W-1:0] next_len [NUM_CH];
    logic [NUM_CH-1:0] status;                   // sticky interrupt flags
    logic [NUM_CH-1:0] next_status;
    logic [NUM_CH-1:0] mask;                     // interrupt mask
    logic [NUM_CH-1:0] next_mask;
    logic next_irq;
    logic [31:0] next_prdata;
    logic next_pslverr;

    logic [NUM_CH-1:0] req_sync;                 // filtered request levels
    logic [NUM_CH-1:0] hw_en_clr;                // hardware enable clear pulses
    logic [NUM_CH-1:0] block_evt;                // block end pulses
    logic [NUM_CH-1:0] abort_evt;                // software stop pulses
    logic [NUM_CH-1:0] active;                   // channel moving words

    dmacc_pkg::dmacc_dec_t dec;                  // decode of current address
    logic setup_ph;                              // apb setup cycle
    logic access_ph;                             // apb access cycle
    logic [31:0] rd_word;                        // read value for this address
    logic [NUM_CH-1:0] irq_evt;                  // events that set status

    ////////////////////////////////////////////////////////////////////////////
    // address decode
    ////////////////////////////////////////////////////////////////////////////

    // map a byte address to a register kind and channel index
    function automatic dmacc_pkg::dmacc_dec_t decode(input logic [`DMACC_ADDR_W-1:0] a);
        dmacc_pkg::dmacc_dec_t d;
        logic [2:0] ix;
        ix = a[`DMACC_IDX_MSB:`DMACC_IDX_LSB];
        d.kind = dmacc_pkg::DMACC_K_NONE;
        d.idx = ix;
        if (a[1:0] != 2'h0) begin
            d.kind = dmacc_pkg::DMACC_K_NONE;           // misaligned
        end else if ((a & `DMACC_BANK_MASK) == `DMACC_CTRL_BASE) begin
            if (32'(ix) < NUM_CH) begin
                d.kind = dmacc_pkg::DMACC_K_CTRL;
            end
        end else if ((a & `DMACC_BANK_MASK) == `DMACC_LEN_BASE) begin
            if (32'(ix) < NUM_CH) begin
                d.kind = dmacc_pkg::DMACC_K_LEN;
            end
        end else if (a == `DMACC_STATUS_OFF) begin
            d.kind = dmacc_pkg::DMACC_K_STATUS;
        end else if (a == `DMACC_MASK_OFF) begin
            d.kind = dmacc_pkg::DMACC_K_MASK;
        end
        return d;
    endfunction

    // true for a write access to the given kind and channel
    function automatic logic wr_hit(input dmacc_pkg::dmacc_dec_t d, input dmacc_pkg::dmacc_kind_t k,
                                    input int unsigned ch, input logic acc, input logic wr);
        return acc && wr && (d.kind == k) && (32'(d.idx) == ch);
    endfunction

    ////////////////////////////////////////////////////////////////////////////
    // request synchronisers and channel sequencers
    ////////////////////////////////////////////////////////////////////////////

    // asynchronous request pins to pclk
    dmacc_sync #(
        .W(NUM_CH)
    ) u_req_sync (
        .pclk(pclk),
        .presetn(presetn),
        .pin(periph_req),
        .level(req_sync)
    );

    // one sequencer per channel, each on its own register
    for (genvar g = 0; g < NUM_CH; g++) begin : g_ch
        dmacc_channel #(
            .CNT_W(CNT_W),
            .LINE_WORDS(LINE_WORDS)
        ) u_chan (
            .pclk(pclk),
            .presetn(presetn),
            .ctrl(ctrl[g]),
            .len(len[g]),
            .req(req_sync[g]),
            .word_done(word_done[g]),
            .word_req(word_req[g]),
            .req_ack(req_ack[g]),
            .hw_en_clr(hw_en_clr[g]),
            .block_evt(block_evt[g]),
            .abort_evt(abort_evt[g]),
            .active(active[g])
        );
    end

    ////////////////////////////////////////////////////////////////////////////
    // apb slave: decode, read mux, response
    ////////////////////////////////////////////////////////////////////////////

    // phases and read value; read data is captured in setup, answered in access
    always_comb begin
        setup_ph = psel && !penable;
        access_ph = psel && penable;
        dec = decode(paddr);
        rd_word = 32'h0000_0000;
        case (dec.kind)
            dmacc_pkg::DMACC_K_CTRL: rd_word = {8'h00, ctrl[dec.idx]};
            dmacc_pkg::DMACC_K_LEN: rd_word = 32'(len[dec.idx]);
            dmacc_pkg::DMACC_K_STATUS: begin
                rd_word[NUM_CH-1:0] = status;
                rd_word[`DMACC_ACTIVE_LSB +: NUM_CH] = active;
            end
            dmacc_pkg::DMACC_K_MASK: rd_word[NUM_CH-1:0] = mask;
            default: rd_word = 32'h0000_0000;                       // unmapped reads zero
        endcase
        next_prdata = setup_ph ? rd_word : prdata;
        next_pslverr = setup_ph ? (dec.kind == dmacc_pkg::DMACC_K_NONE) : pslverr;
        pready = access_ph;                                          // zero wait states
    end

    // register read data and error flag
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            prdata <= 32'h0000_0000;
            pslverr <= 1'b0;
        end else begin
            prdata <= next_prdata;
            pslverr <= next_pslverr;
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // control and length registers
    ////////////////////////////////////////////////////////////////////////////

    // software writes win over the hardware enable clear in the same cycle
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            next_ctrl[i] = ctrl[i];
            next_len[i] = len[i];
            if (wr_hit(dec, dmacc_pkg::DMACC_K_CTRL, i, access_ph, pwrite)) begin
                next_ctrl[i] = dmacc_pkg::dmacc_ctrl_t'(pwdata[`DMACC_CTRL_W-1:0]);
            end else if (hw_en_clr[i]) begin
                next_ctrl[i].channel_enable = 1'b0;
            end
            if (wr_hit(dec, dmacc_pkg::DMACC_K_LEN, i, access_ph, pwrite)) begin
                next_len[i] = pwdata[CNT_W-1:0];
            end
        end
    end

    // register control and length words
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl[i] <= dmacc_pkg::dmacc_ctrl_t'(`DMACC_CTRL_RST);
                len[i] <= '0;
            end
        end else begin
            for (int i = 0; i < NUM_CH; i++) begin
                ctrl[i] <= next_ctrl[i];
                len[i] <= next_len[i];
            end
        end
    end

    ////////////////////////////////////////////////////////////////////////////
    // interrupt status, mask and output
    ////////////////////////////////////////////////////////////////////////////

    // events set flags only with irq enable; a status read clears what it returned
    always_comb begin
        for (int i = 0; i < NUM_CH; i++) begin
            irq_evt[i] = (block_evt[i] || abort_evt[i]) && ctrl[i].channel_irq_enable;
        end
        next_status = status;
        if (access_ph && !pwrite && dec.kind == dmacc_pkg::DMACC_K_STATUS) begin
            next_status = status & ~prdata[NUM_CH-1:0];
        end
        next_status = next_status | irq_evt;                         // set beats clear
        next_mask = mask;
        if (access_ph && pwrite && dec.kind == dmacc_pkg::DMACC_K_MASK) begin
            next_mask = pwdata[NUM_CH-1:0];
        end
        next_irq = |(next_status & next_mask);
    end

    // register flags, mask and interrupt line
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            status <= '0;
            mask <= '0;
            irq <= 1'b0;
        end else begin
            status <= next_status;
            mask <= next_mask;
            irq <= next_irq;
        end
    end

endmodule // dmacc_top

// ===== verif/dmacc_top_sva.sv
// checker on the ports of the dma channel control top
// assumes it is bound onto dmacc_top, one pclk domain
module dmacc_top_sva #(
    parameter int NUM_CH = 6
) (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [11:0] paddr,
    input wire logic psel,
    input wire logic penable,
    input wire logic pwrite,
    input wire logic [31:0] prdata,
    input wire logic pready,
    input wire logic pslverr,
    input wire logic [NUM_CH-1:0] req_ack,
    input wire logic [NUM_CH-1:0] word_req,
    input wire logic [NUM_CH-1:0] word_done
);
    default clocking dmacc_cb @(posedge pclk); endclocking
    default disable iff (!presetn);
    ////////////////////////////////////////////////////////////
    // register bus
    AST_READY: assert property (pready == (psel && penable)) else $error("pready off access");
    AST_UNMAPPED: assert property (psel && !penable && paddr == 12'h048 |=> pslverr) else $error("no slverr");
    AST_CTRL_OK: assert property (psel && !penable && paddr < 12'h018 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("ctrl refused");
    AST_CTRL_TOP: assert property (psel && penable && !pwrite && paddr < 12'h018 |-> prdata[31:24] == 8'h00)
        else $error("ctrl top bits set");
    ////////////////////////////////////////////////////////////
    // channel link
    AST_ACK_RUN: assert property (req_ack != '0 |=> (word_req & $past(req_ack)) == $past(req_ack))
        else $error("no word after ack");
    AST_ACK_PULSE: assert property ((req_ack & $past(req_ack)) == '0) else $error("ack held");
    AST_ACK_EXCL: assert property ((req_ack & word_req) == '0) else $error("ack while running");
    AST_WORD_HOLD: assert property ((~word_req & $past(word_req) & ~$past(word_done)) == '0)
        else $error("word dropped in flight");
endmodule // dmacc_top_sva

// ===== verif/dmacc_periph.sv
// far side: requesting peripherals and a datapath storing words
// assumes req_ack and word_req come from the channel block on pclk
module dmacc_periph (
    input wire logic pclk,
    input wire logic presetn,
    input wire logic [5:0] want,
    input wire logic slow,
    input wire logic [5:0] req_ack,
    input wire logic [5:0] word_req,
    output logic [5:0] periph_req,
    output logic [5:0] word_done
);
    logic [4:0] wait_cnt [6]; // cycles spent on the word in flight
    // request held until taken, low while served; store after 2 or 30 cycles
    always_ff @(posedge pclk or negedge presetn) begin
        if (!presetn) begin
            periph_req <= 6'h00;
            word_done <= 6'h00;
            for (int i = 0; i < 6; i++) wait_cnt[i] <= 5'h00;
        end else begin
            periph_req <= want & ~req_ack & ~word_req;
            for (int i = 0; i < 6; i++) begin
                word_done[i] <= word_req[i] && !word_done[i] && wait_cnt[i] == (slow ? 5'h1e : 5'h02);
                wait_cnt[i] <= (word_req[i] && !word_done[i]) ? wait_cnt[i] + 5'h01 : 5'h00;
            end
        end
    end
endmodule // dmacc_periph

// ===== verif/tb_dma_channel_control.sv
// self-checking bench for the dma channel control block
// assumes dmacc_top, dmacc_periph and dmacc_top_sva are compiled first
module tb_dma_channel_control;
    timeunit 1ns;
    timeprecision 1ps;
    typedef struct packed {logic e; logic [11:0] a; logic [31:0] w; logic [31:0] x;} dmacc_row_t;
    logic pclk = 1'h0, presetn = 1'h0, psel = 1'h0, penable = 1'h0, pwrite = 1'h0, slow = 1'h0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0, prdata, rdat;
    logic pready, pslverr, irq, rerr;
    logic [5:0] want = 6'h00, periph_req, req_ack, word_req, word_done;
    int miscompares = 0, checked = 0, words = 0, base, k, m;
    // error flag, address, write value, read back
    dmacc_row_t rows [4] = '{{1'h0, 12'h000, 32'hff7fffff, 32'h007fffff},
        {1'h0, 12'h014, 32'h0047ffff, 32'h0047ffff}, {1'h0, 12'h044, 32'h3f, 32'h3f},
        {1'h1, 12'h048, 32'hffffffff, 32'h0}};
    dmacc_top uut (.pclk(pclk), .presetn(presetn), .paddr(paddr), .psel(psel), .penable(penable),
        .pwrite(pwrite), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr),
        .periph_req(periph_req), .req_ack(req_ack), .word_req(word_req), .word_done(word_done), .irq(irq));
    dmacc_periph u_far (.pclk(pclk), .presetn(presetn), .want(want), .slow(slow), .req_ack(req_ack),
        .word_req(word_req), .periph_req(periph_req), .word_done(word_done));
    always #5 pclk = ~pclk;
    always @(posedge pclk) words <= words + $countones(word_done); // stored words
    ////////////////////////////////////////////////////////////
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        checked++;
        if (got !== exp) begin
            miscompares++;
            $display("[ERR] t=%0t got %h exp %h", $time, got, exp);
        end
    endtask
    // one apb transfer, waits for pready
    task automatic apb(input logic wr, input logic [11:0] a, input logic [31:0] d);
        int n;
        n = 0;
        psel <= 1'h1;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge pclk);
        penable <= 1'h1;
        do begin
            @(posedge pclk);
            n++;
        end while (pready !== 1'h1 && n < 50);
        if (n == 50) miscompares++;
        rdat = prdata;
        rerr = pslverr;
        psel <= 1'h0;
        penable <= 1'h0;
        @(posedge pclk);
    endtask
    task automatic wait_words(input int n);
        for (int i = 0; i < 400 && words - base < n; i++) @(posedge pclk);
    endtask
    task automatic rst();
        presetn <= 1'h0;
        repeat (16) @(posedge pclk);
        presetn <= 1'h1;
        @(posedge pclk);
        for (k = 0; k < 6; k++) begin
            apb(1'h0, 12'(4 * k), 32'h0);
            chk(rdat, 32'h0);
        end
        $display("reset test done");
    endtask
    task automatic close_out();
        $display("comparisons %0d mismatches %0d", checked, miscompares);
        if (miscompares == 0 && checked > 0) begin
            $display("verification passed");
        end else begin
            $display("verification failed");
        end
        $finish;
    endtask
    ////////////////////////////////////////////////////////////
    initial begin
        repeat (20000) @(posedge pclk);
        miscompares++;
        close_out();
    end
    initial begin
        rst();
        foreach (rows[i]) apb(1'h1, rows[i].a, rows[i].w);
        foreach (rows[i]) begin
            apb(1'h0, rows[i].a, 32'h0);
            chk(rdat, rows[i].x);
            chk(rerr, rows[i].e);
        end
        $display("register test done");
        // every mode on channel 4, length 2, request held
        for (m = 0; m < 6; m++) begin
            apb(1'h1, 12'h030, 32'h2);
            base = words;
            apb(1'h1, 12'h010, 32'h00c00000 | (m << 19));
            want[4] <= 1'h1;
            wait_words(2);
            repeat (40) @(posedge pclk);
            if (m < 4) chk(words - base, 32'h2);
            chk(irq, m < 4);
            apb(1'h0, 12'h010, 32'h0);
            chk(rdat[23], m > 3);
            apb(1'h0, 12'h040, 32'h0);
            chk(rdat[4], m < 4);
            repeat (2) @(posedge pclk);
            chk(irq, 1'h0);
            want[4] <= 1'h0;
            apb(1'h1, 12'h010, 32'h0);
            repeat (20) @(posedge pclk);
            apb(1'h0, 12'h040, 32'h0);
            chk(rdat[4], 1'h0);
        end
        $display("mode test done");
        apb(1'h1, 12'h044, 32'h0);
        base = words;
        apb(1'h1, 12'h010, 32'h00d80000);
        wait_words(2);
        repeat (10) @(posedge pclk);
        chk(irq, 1'h0);
        apb(1'h1, 12'h044, 32'h3f);
        repeat (2) @(posedge pclk);
        chk(irq, 1'h1);
        apb(1'h0, 12'h040, 32'h0);
        repeat (2) @(posedge pclk);
        chk(irq, 1'h0);
        $display("mask test done");
        // software stop with a slow word in flight
        slow <= 1'h1;
        apb(1'h1, 12'h034, 32'h4);
        base = words;
        apb(1'h1, 12'h014, 32'h00c00000);
        want[5] <= 1'h1;
        for (k = 0; k < 100 && word_req[5] !== 1'h1; k++) @(posedge pclk);
        apb(1'h1, 12'h014, 32'h00400000);
        chk(word_req[5], 1'h1);
        wait_words(1);
        repeat (20) @(posedge pclk);
        chk(words - base, 32'h1);
        chk(word_req[5], 1'h0);
        apb(1'h0, 12'h040, 32'h0);
        chk(rdat[5], 1'h1);
        $display("stop test done");
        rst();
        close_out();
    end
endmodule // tb_dma_channel_control

bind dmacc_top dmacc_top_sva #(.NUM_CH(NUM_CH)) u_sva (.pclk(pclk), .presetn(presetn), .paddr(paddr),
    .psel(psel), .penable(penable), .pwrite(pwrite), .prdata(prdata), .pready(pready), .pslverr(pslverr),
    .req_ack(req_ack), .word_req(word_req), .word_done(word_done));
